// ===== common/ref_status_pkg.sv
package ref_status_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [6:0] OFS_PRIORITY_RANK_LOW   = 7'h0a;
  localparam logic [6:0] OFS_PRIORITY_RANK_HIGH  = 7'h0b;
  localparam logic [6:0] OFS_LOOP_FREQUENCY_LOW  = 7'h0c;
  localparam logic [6:0] OFS_LOOP_FREQUENCY_MID  = 7'h0d;
  localparam logic [6:0] OFS_INPUT_VALIDITY_LOW  = 7'h0e;
  localparam logic [6:0] OFS_INPUT_VALIDITY_HIGH = 7'h0f;
  localparam logic [6:0] OFS_SE_INPUT_ALARMS     = 7'h11;

  // Values after reset
  localparam logic [7:0] RST_STATUS    = 8'h00;
  localparam logic [7:0] RST_SE_ALARMS = 8'h22;

  // Frequency count weight, ppm per count
  localparam real FREQ_PPM_PER_COUNT = 0.0003068;

  // Source codes
  localparam logic [3:0] SRC_NONE        = 4'h0;
  localparam logic [3:0] SRC_ONE_SE      = 4'h3;
  localparam logic [3:0] SRC_TWO_SE      = 4'h4;
  localparam logic [3:0] SRC_ONE_DIFF    = 4'h5;
  localparam logic [3:0] SRC_TWO_DIFF    = 4'h6;
  localparam logic [3:0] SRC_STANDBY     = 4'h9;

  // Validity bit positions
  localparam int VLD_ONE_SE   = 2;
  localparam int VLD_TWO_SE   = 3;
  localparam int VLD_ONE_DIFF = 4;
  localparam int VLD_TWO_DIFF = 5;
  localparam int VLD_STANDBY  = 0;

  // Alarm nibble bit positions
  localparam int ALM_PHASE    = 0;
  localparam int ALM_ACTIVITY = 1;

  // Main loop operating state codes
  localparam logic [2:0] LOOP_FREE_RUN        = 3'h1;
  localparam logic [2:0] LOOP_HOLDOVER        = 3'h2;
  localparam logic [2:0] LOOP_LOCKED          = 3'h4;
  localparam logic [2:0] LOOP_SECOND_PRELOCK  = 3'h5;
  localparam logic [2:0] LOOP_PRELOCK         = 3'h6;
  localparam logic [2:0] LOOP_PHASE_LOST      = 3'h7;

  typedef enum logic [2:0] {
    ST_FREE_RUN,
    ST_HOLDOVER,
    ST_LOCKED,
    ST_SECOND_PRELOCK,
    ST_PRELOCK,
    ST_PHASE_LOST
  } loop_state_type;

endpackage

// ===== logic/src_rank.sv
`timescale 1ns/1ps
module src_rank
  import ref_status_pkg::*;
#(
  parameter int N_SRC = 5
) (
  input  wire logic [N_SRC-1:0]   i_valid,
  input  wire logic [N_SRC*4-1:0] i_prio,
  input  wire logic [N_SRC*4-1:0] i_code,
  output logic      [3:0]         o_first,
  output logic      [3:0]         o_second,
  output logic      [3:0]         o_third
);

  // Combinational ranking; lowest nonzero priority wins, ties by index
  logic [N_SRC-1:0] used;
  logic [3:0]       best_code [3];
  logic [4:0]       best_prio;
  int               best_idx;

  always_comb begin
    used = '0;
    best_prio = 5'h1f;
    best_idx = 0;
    for (int r = 0; r < 3; r++) begin
      best_code[r] = SRC_NONE;
      best_prio = 5'h1f;
      best_idx = -1;
      for (int k = 0; k < N_SRC; k++) begin
        if (i_valid[k] && !used[k] && (i_prio[k*4 +: 4] != 4'h0) &&
            ({1'b0, i_prio[k*4 +: 4]} < best_prio)) begin
          best_prio = {1'b0, i_prio[k*4 +: 4]};
          best_idx = k;
        end
      end
      for (int k = 0; k < N_SRC; k++) begin
        if (k == best_idx) begin
          used[k] = 1'b1;
          best_code[r] = i_code[k*4 +: 4];
        end
      end
    end
    o_first  = best_code[0];
    o_second = best_code[1];
    o_third  = best_code[2];
  end

endmodule // src_rank

// ===== logic/ref_status_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Loop state codes 001,010,100,101,110,111 only
// - Three rank fields, 0000 when too few
// - Source codes 3,4,5,6,9 identify five inputs
// - Offset 0x0a low nibble: selected source
// - Select bit chooses main or aux frequency
// - Signed frequency, low byte 0x0c, high 0x0d
// - Validity low bits 2..5, high when alarm-free
// - Validity high bit 0 is standby input
// - Alarm register 0x11, reset value 0x22
// - Alarm register writable only in test mode
// - Nibble bit 1 activity, bit 0 phase
module ref_status_regs
  import ref_status_pkg::*;
(
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst,
  input  wire logic [ref_status_pkg::ADDR_W-1:0] i_addr,
  input  wire logic                        i_wr_en,
  input  wire logic                        i_rd_en,
  input  wire logic [ref_status_pkg::DATA_W-1:0] i_wdata,
  output logic      [ref_status_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                        i_test_mode,
  input  wire logic                        i_loop_report_select,
  input  wire ref_status_pkg::loop_state_type i_main_loop_state,
  input  wire logic [15:0]                 i_main_loop_freq,
  input  wire logic [15:0]                 i_aux_loop_freq,
  input  wire logic [4:0]                  i_no_activity,
  input  wire logic [4:0]                  i_phase_alarm,
  input  wire logic [19:0]                 i_priority,
  input  wire logic [2:0]                  i_selected_idx,
  output logic      [2:0]                  o_main_loop_code
);
  import ref_status_pkg::*;

  // Input order: one_se, two_se, one_diff, two_diff, standby
  localparam logic [19:0] SRC_CODES = {SRC_STANDBY, SRC_TWO_DIFF,
                                       SRC_ONE_DIFF, SRC_TWO_SE,
                                       SRC_ONE_SE};

  logic [4:0]  valid_d;
  logic [4:0]  valid_q;
  logic [19:0] prio_q;
  logic [15:0] freq_d;
  logic [15:0] freq_q;
  logic [3:0]  sel_code_d;
  logic [3:0]  sel_code_q;
  logic [2:0]  state_code_d;
  logic [2:0]  state_code_q;
  logic [7:0]  se_alarm_q;
  logic [7:0]  se_alarm_d;
  logic        alarm_wr;
  logic [3:0]  rank1;
  logic [3:0]  rank2;
  logic [3:0]  rank3;
  logic [7:0]  rank_low_img;
  logic [7:0]  rank_high_img;
  logic [7:0]  vld_low_img;
  logic [7:0]  vld_high_img;
  logic [7:0]  rdata_d;

  // An input is valid only with no outstanding alarm
  for (genvar g = 0; g < 5; g++) begin : gen_valid
    assign valid_d[g] = ~(i_no_activity[g] | i_phase_alarm[g]);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      valid_q <= '0;
    end else begin
      valid_q <= valid_d;
    end
  end

  // Priorities registered with validity so ranks see one cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prio_q <= '0;
    end else begin
      prio_q <= i_priority;
    end
  end

  src_rank #(
    .N_SRC (5)
  ) u_rank (
    .i_valid  (valid_q),
    .i_prio   (prio_q),
    .i_code   (SRC_CODES),
    .o_first  (rank1),
    .o_second (rank2),
    .o_third  (rank3)
  );

  // Report select only steers; both loops keep running behind it
  always_comb begin
    freq_d = i_main_loop_freq;
    if (i_loop_report_select) begin
      freq_d = i_aux_loop_freq;
    end
  end

  // Frequency captured as one word so both bytes stay coherent
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      freq_q <= '0;
    end else begin
      freq_q <= freq_d;
    end
  end

  // Index 5 and above means nothing selected
  always_comb begin
    sel_code_d = SRC_NONE;
    case (i_selected_idx)
      3'd0:    sel_code_d = SRC_ONE_SE;
      3'd1:    sel_code_d = SRC_TWO_SE;
      3'd2:    sel_code_d = SRC_ONE_DIFF;
      3'd3:    sel_code_d = SRC_TWO_DIFF;
      3'd4:    sel_code_d = SRC_STANDBY;
      default: sel_code_d = SRC_NONE;
    endcase
  end

  // Selected source may differ from top rank when non-revertive
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sel_code_q <= SRC_NONE;
    end else begin
      sel_code_q <= sel_code_d;
    end
  end

  // Unused codes 000 and 011 can never be produced
  always_comb begin
    state_code_d = LOOP_FREE_RUN;
    case (i_main_loop_state)
      ST_FREE_RUN:       state_code_d = LOOP_FREE_RUN;
      ST_HOLDOVER:       state_code_d = LOOP_HOLDOVER;
      ST_LOCKED:         state_code_d = LOOP_LOCKED;
      ST_SECOND_PRELOCK: state_code_d = LOOP_SECOND_PRELOCK;
      ST_PRELOCK:        state_code_d = LOOP_PRELOCK;
      ST_PHASE_LOST:     state_code_d = LOOP_PHASE_LOST;
      default:           state_code_d = LOOP_FREE_RUN;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_code_q <= LOOP_FREE_RUN;
    end else begin
      state_code_q <= state_code_d;
    end
  end
  assign o_main_loop_code = state_code_q;

  // Live alarms unless test mode lets software override
  always_comb begin
    se_alarm_d = 8'h00;
    se_alarm_d[ALM_PHASE]        = i_phase_alarm[0];
    se_alarm_d[ALM_ACTIVITY]     = i_no_activity[0];
    se_alarm_d[4 + ALM_PHASE]    = i_phase_alarm[1];
    se_alarm_d[4 + ALM_ACTIVITY] = i_no_activity[1];
  end

  // Outside test mode a write here is dropped like any other
  assign alarm_wr = i_wr_en && i_test_mode &&
                    (i_addr == OFS_SE_INPUT_ALARMS);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      se_alarm_q <= RST_SE_ALARMS;
    end else if (alarm_wr) begin
      // Test write holds for one cycle, then live alarms return
      se_alarm_q <= i_wdata;
    end else begin
      se_alarm_q <= se_alarm_d;
    end
  end

  // Rank byte carries the selection in its low nibble
  always_comb begin
    rank_low_img  = {rank1, sel_code_q};
    rank_high_img = {rank3, rank2};
  end

  // Unused validity bits stay zero
  always_comb begin
    vld_low_img               = 8'h00;
    vld_high_img              = 8'h00;
    vld_low_img[VLD_ONE_SE]   = valid_q[0];
    vld_low_img[VLD_TWO_SE]   = valid_q[1];
    vld_low_img[VLD_ONE_DIFF] = valid_q[2];
    vld_low_img[VLD_TWO_DIFF] = valid_q[3];
    vld_high_img[VLD_STANDBY] = valid_q[4];
  end

  // Read mux has no side effects; writes reach only the alarm register, in test mode
  always_comb begin
    rdata_d = 8'h00;
    case (i_addr)
      OFS_PRIORITY_RANK_LOW:   rdata_d = rank_low_img;
      OFS_PRIORITY_RANK_HIGH:  rdata_d = rank_high_img;
      OFS_LOOP_FREQUENCY_LOW:  rdata_d = freq_q[7:0];
      OFS_LOOP_FREQUENCY_MID:  rdata_d = freq_q[15:8];
      OFS_INPUT_VALIDITY_LOW:  rdata_d = vld_low_img;
      OFS_INPUT_VALIDITY_HIGH: rdata_d = vld_high_img;
      OFS_SE_INPUT_ALARMS:     rdata_d = se_alarm_q;
      default:                 rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata <= RST_STATUS;
    end else if (i_rd_en) begin
      o_rdata <= rdata_d;
    end
  end

endmodule // ref_status_regs

// ===== test/ref_status_sva.sv
`timescale 1ns/1ps
module ref_status_sva
  import ref_status_pkg::*;
(
  input wire logic           i_ref_clk,
  input wire logic           i_rst,
  input wire logic [6:0]     i_addr,
  input wire logic           i_wr_en,
  input wire logic           i_rd_en,
  input wire logic [7:0]     i_wdata,
  input wire logic [7:0]     o_rdata,
  input wire logic           i_test_mode,
  input wire logic           i_loop_report_select,
  input wire loop_state_type i_main_loop_state,
  input wire logic [15:0]    i_main_loop_freq,
  input wire logic [15:0]    i_aux_loop_freq,
  input wire logic [4:0]     i_no_activity,
  input wire logic [4:0]     i_phase_alarm,
  input wire logic [2:0]     o_main_loop_code
);
  localparam logic [2:0] CODE [6] = '{3'h1,3'h2,3'h4,3'h5,3'h6,3'h7};
  logic pr_q;
  wire [4:0] ok = ~(i_no_activity | i_phase_alarm);
  wire [15:0] f = i_loop_report_select ? i_aux_loop_freq : i_main_loop_freq;
  wire [7:0] al = {2'h0, i_no_activity[1], i_phase_alarm[1],
                   2'h0, i_no_activity[0], i_phase_alarm[0]};
  // Status registers still hold reset values one cycle after reset
  always_ff @(posedge i_ref_clk) pr_q <= i_rst;
  // Plain net, so the read qualifier is sampled like the rest
  wire rdv = i_rd_en && !pr_q;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  vld_low_a: assert property (rdv && i_addr == 7'h0e |=>
    o_rdata == {2'h0, $past(ok[3:0], 2), 2'h0}) else $error("bad 0e");
  vld_high_a: assert property (rdv && i_addr == 7'h0f |=>
    o_rdata == {7'h0, $past(ok[4], 2)}) else $error("bad 0f");
  freq_low_a: assert property (rdv && i_addr == 7'h0c |=>
    o_rdata == $past(f[7:0], 2)) else $error("bad 0c");
  freq_high_a: assert property (rdv && i_addr == 7'h0d |=>
    o_rdata == $past(f[15:8], 2)) else $error("bad 0d");
  code_map_a: assert property (1'b1 |=>
    o_main_loop_code == CODE[$past(i_main_loop_state)]) else $error("code");
  alarm_live_a: assert property (rdv && i_addr == 7'h11 &&
    !$past(i_wr_en) |=> o_rdata == $past(al, 2)) else $error("bad 11");
  alarm_reset_a: assert property ($fell(i_rst) && i_rd_en &&
    i_addr == 7'h11 |=> o_rdata == 8'h22) else $error("bad reset");
  test_wr_a: assert property (i_wr_en && i_test_mode &&
    i_addr == 7'h11 ##1 (rdv && i_addr == 7'h11) |=>
    o_rdata == $past(i_wdata, 2)) else $error("test write");
  hold_data_a: assert property (!i_rd_en |=> $stable(o_rdata))
    else $error("rdata moved");
  cover property (rdv && i_addr == 7'h0c && i_loop_report_select);
  cover property (i_wr_en && i_test_mode ##1 (rdv && i_addr == 7'h11));
  cover property ($fell(i_rst) && i_rd_en);
endmodule // ref_status_sva
bind ref_status_regs ref_status_sva i_chk (.i_ref_clk, .i_rst, .i_addr,
  .i_wr_en, .i_rd_en, .i_wdata, .o_rdata, .i_test_mode,
  .i_loop_report_select, .i_main_loop_state, .i_main_loop_freq,
  .i_aux_loop_freq, .i_no_activity, .i_phase_alarm, .o_main_loop_code);

// ===== test/ref_status_regs_tb.sv
`timescale 1ns/1ps
module ref_status_regs_tb;
  import ref_status_pkg::*;
  localparam logic [2:0] CODE [6] = '{3'h1,3'h2,3'h4,3'h5,3'h6,3'h7};
  logic clk = 0, rst = 1, wr = 0, rd = 0, tm = 0, sel = 0;
  logic [6:0] addr = 7'h00;
  logic [7:0] wd = 8'h00, rdata;
  logic [15:0] mf = 16'h0000, af = 16'h0000;
  logic [4:0] na = 5'h1f, pa = 5'h00;
  logic [19:0] pri = 20'h00000;
  logic [2:0] sx = 3'h7, code;
  loop_state_type st = ST_FREE_RUN;
  int err_count = 0, samples_checked = 0, cyc = 0;
  ref_status_regs i_dut (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr),
    .i_wr_en(wr), .i_rd_en(rd), .i_wdata(wd), .o_rdata(rdata),
    .i_test_mode(tm), .i_loop_report_select(sel), .i_main_loop_state(st),
    .i_main_loop_freq(mf), .i_aux_loop_freq(af), .i_no_activity(na),
    .i_phase_alarm(pa), .i_priority(pri), .i_selected_idx(sx),
    .o_main_loop_code(code));
  initial forever #2.5 clk = ~clk;
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, runs far beyond the roughly 75 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(logic [7:0] g, logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Checked a cycle late so the held read data is tested too
  task automatic rdc(logic [6:0] a, logic [7:0] e);
    addr = a;
    rd = 1;
    @(negedge clk) rd = 0;
    @(negedge clk) chk(rdata, e);
  endtask
  task automatic wrt(logic [6:0] a, logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1;
    @(negedge clk) wr = 0;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    rdc(7'h11, 8'h22);
    chk({5'h0, code}, 8'h01);
    for (int a = 10; a < 17; a++) rdc(a[6:0], 8'h00);
    $display("test reset done");
    na = 5'h06;
    pa = 5'h08;
    pri = 20'h10002;
    sx = 3'h0;
    @(negedge clk);
    rdc(7'h0e, 8'h04);
    rdc(7'h0f, 8'h01);
    rdc(7'h11, 8'h20);
    rdc(7'h0a, 8'h93);
    rdc(7'h0b, 8'h03);
    wrt(7'h0e, 8'hff);
    rdc(7'h0e, 8'h04);
    wrt(7'h11, 8'hff);
    rdc(7'h11, 8'h20);
    tm = 1;
    wrt(7'h11, 8'h5a);
    rdc(7'h11, 8'h5a);
    tm = 0;
    $display("test partial done");
    na = 5'h00;
    pa = 5'h00;
    pri = 20'h51234;
    sx = 3'h4;
    @(negedge clk);
    rdc(7'h0e, 8'h3c);
    rdc(7'h0a, 8'h69);
    rdc(7'h0b, 8'h45);
    mf = 16'h8123;
    af = 16'h7f01;
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      @(negedge clk);
      rdc(7'h0c, s ? 8'h01 : 8'h23);
      rdc(7'h0d, s ? 8'h7f : 8'h81);
    end
    for (int i = 0; i < 6; i++) begin
      st = loop_state_type'(i);
      @(negedge clk);
      chk({5'h0, code}, {5'h0, CODE[i]});
    end
    $display("test full done");
    wrap_up();
  end
endmodule // ref_status_regs_tb
